// ---- rtl/jtl_pkg.sv ----
package jtl_pkg;

    // ------------------------------------------------------------
    // line coding and link states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        JTL_CODE_8B10B = 1'b0,
        JTL_CODE_64B66B = 1'b1
    } jtl_code_t;

    typedef enum logic [1:0] {
        JTL_ST_IDLE = 2'b00,
        JTL_ST_CGS = 2'b01,
        JTL_ST_ILAS = 2'b10,
        JTL_ST_DATA = 2'b11
    } jtl_state_t;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam int JTL_MAX_LANES = 16;
    localparam int JTL_LANE_W = 5;
    localparam int JTL_ILAS_MF = 4;
    localparam int JTL_MF_W = 9;
    localparam logic [7:0] JTL_K28_5 = 8'hbc;
    localparam logic [7:0] JTL_K28_0 = 8'h1c;
    localparam logic [7:0] JTL_K28_3 = 8'h7c;
    localparam logic [1:0] JTL_SH_DATA = 2'h1;
    localparam logic [14:0] JTL_SCR_SEED = 15'h7fff;
    localparam logic [57:0] JTL_SCR64_SEED = 58'h3ffffffffffffff;
    localparam logic [8:0] JTL_K_DEFAULT = 9'h020;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [63:0] data;
    } jtl_word_t;

    typedef struct packed {
        logic [63:0] data;
        logic [7:0] ctrl;
        logic [1:0] sync_hdr;
        logic mf_start;
    } jtl_lane_word_t;

    typedef struct packed {
        jtl_code_t code;
        logic [JTL_LANE_W-1:0] lanes;
        logic fec_en;
        logic scr_en;
        logic [8:0] k_frames;
        logic sync_for_osc;
    } jtl_cfg_t;

endpackage

// ---- rtl/jtl_skid_buf.sv ----
`timescale 1ns/100ps
`default_nettype none

module jtl_skid_buf #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 2
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);

    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } jtl_buf_state_t;

    jtl_buf_state_t st_reg;
    jtl_buf_state_t st_next;
    logic push;
    logic pop;

    assign o_ready = (st_reg.cnt != (PW+1)'(DEPTH));
    assign o_valid = (st_reg.cnt != '0);
    assign o_data = st_reg.mem[st_reg.rp];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = i_data;
            st_next.wp = (st_reg.wp == PW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = (st_reg.rp == PW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/jtl_tx_link.sv ----
`timescale 1ns/100ps
`default_nettype none

// Operation
// - each lane carries 8B/10B or 64B/66B coding, chosen by configuration
// - up to sixteen lanes can be enabled
// - 64B/66B blocks are framed by a sync header in every block
// - in 64B/66B the handshake is ignored unless it triggers oscillator sync
// - one device clock runs the whole block; no link clock
// - sysref edge resets the multiframe or extended multiblock counter
// - forward error correction optional in 64B/66B
// - no three-bit CRC is generated
// - no command channel and no 64B/80B layer
// - subclass 1 transmitter, subclass 0 receivers work, no subclass 2
// - lanes of one link align together; no multipoint reference
// - handshake timing accepted for both A and B revisions
// - 8B/10B formats remain usable by B-revision receivers
// - in 8B/10B, handshake low sends continuous K28.5 on every lane
// - after handshake rises wait for next multiframe boundary, then alignment
// - alignment sequence is four multiframes, K28.0 first, K28.3 last
// - scrambling always on in 64B/66B, optional in 8B/10B
module jtl_tx_link #(
    parameter int LANES = jtl_pkg::JTL_MAX_LANES
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire jtl_pkg::jtl_cfg_t i_cfg,
    input wire logic i_link_en,
    input wire logic i_handshake_single_ended_input,
    input wire logic i_sysref,
    input wire logic i_valid,
    output logic o_ready,
    input wire jtl_pkg::jtl_word_t i_word,
    output logic [LANES-1:0] o_lane_en,
    output jtl_pkg::jtl_lane_word_t o_lane_word,
    output logic o_lane_valid,
    output logic o_fec_en,
    output logic o_osc_sync,
    output logic [1:0] o_state
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] hs_sync;
        logic [1:0] sr_sync;
        logic hs_prev;
        logic sr_prev;
        jtl_pkg::jtl_state_t state;
        jtl_pkg::jtl_cfg_t cfg;
        logic [8:0] frame_cnt;
        logic [1:0] ilas_mf;
        logic [14:0] scr;
        logic [57:0] scr64;
        logic ilas_wait;
        logic [LANES-1:0] lane_en;
        jtl_pkg::jtl_lane_word_t out;
        logic out_valid;
        logic osc_sync;
    } jtl_state_vec_t;

    jtl_state_vec_t st_reg;
    jtl_state_vec_t st_next;
    logic buf_valid;
    logic buf_ready;
    logic [63:0] buf_data;
    logic mf_edge;
    logic hs;
    logic sr_edge;

    // 2-entry buffer so a stall while aligning loses no sample word
    jtl_skid_buf #(
        .WIDTH(64),
        .DEPTH(2)
    ) u_buf (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_valid(i_valid),
        .o_ready(o_ready),
        .i_data(i_word.data),
        .o_valid(buf_valid),
        .i_ready(buf_ready),
        .o_data(buf_data)
    );

    function automatic logic [LANES-1:0] lane_mask(input logic [jtl_pkg::JTL_LANE_W-1:0] n);
        logic [LANES-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            m[i] = (i < int'(n));
        end
        return m;
    endfunction

    function automatic logic [63:0] rep8(input logic [7:0] c);
        return {8{c}};
    endfunction

    assign hs = st_reg.hs_sync[1];
    assign sr_edge = st_reg.sr_sync[1] && !st_reg.sr_prev;
    assign mf_edge = (st_reg.frame_cnt == st_reg.cfg.k_frames - 9'h001);
    assign buf_ready = (st_reg.state == jtl_pkg::JTL_ST_DATA);

    always_comb begin
        st_next = st_reg;
        // two-flop synchronisers for handshake and sysref on the device clock; no second domain exists
        st_next.hs_sync = {st_reg.hs_sync[0], i_handshake_single_ended_input};
        st_next.sr_sync = {st_reg.sr_sync[0], i_sysref};
        st_next.hs_prev = hs;
        st_next.sr_prev = st_reg.sr_sync[1];
        st_next.osc_sync = 1'b0;
        st_next.out_valid = 1'b0;

        // ------------------------------------------------------------
        // multiframe / extended multiblock counter
        // ------------------------------------------------------------
        if (sr_edge) begin
            st_next.frame_cnt = '0;
        end else if (mf_edge) begin
            st_next.frame_cnt = '0;
        end else begin
            st_next.frame_cnt = st_reg.frame_cnt + 9'h001;
        end

        unique case (st_reg.state)
            jtl_pkg::JTL_ST_IDLE: begin
                // configuration only latched here, never while running
                st_next.cfg = i_cfg;
                if (i_cfg.lanes > jtl_pkg::JTL_LANE_W'(LANES)) begin
                    st_next.cfg.lanes = jtl_pkg::JTL_LANE_W'(LANES);
                end
                if (i_cfg.k_frames == 9'h000) begin
                    st_next.cfg.k_frames = jtl_pkg::JTL_K_DEFAULT;
                end
                st_next.cfg.fec_en = i_cfg.fec_en && (i_cfg.code == jtl_pkg::JTL_CODE_64B66B);
                st_next.cfg.scr_en = i_cfg.scr_en || (i_cfg.code == jtl_pkg::JTL_CODE_64B66B);
                st_next.scr = jtl_pkg::JTL_SCR_SEED;
                st_next.scr64 = jtl_pkg::JTL_SCR64_SEED;
                st_next.lane_en = '0;
                if (i_link_en) begin
                    st_next.lane_en = lane_mask(st_next.cfg.lanes);
                    st_next.state = (i_cfg.code == jtl_pkg::JTL_CODE_64B66B) ?
                        jtl_pkg::JTL_ST_DATA : jtl_pkg::JTL_ST_CGS;
                end
            end
            jtl_pkg::JTL_ST_CGS: begin
                st_next.out.data = rep8(jtl_pkg::JTL_K28_5);
                st_next.out.ctrl = 8'hff;
                st_next.out.sync_hdr = '0;
                st_next.out.mf_start = mf_edge;
                st_next.out_valid = 1'b1;
                // rising-edge check on the synced line suits A and B timing
                if (hs && !st_reg.hs_prev) begin
                    st_next.ilas_wait = 1'b1;
                end
                if ((st_reg.ilas_wait || (hs && !st_reg.hs_prev)) && mf_edge) begin
                    st_next.ilas_wait = 1'b0;
                    st_next.ilas_mf = '0;
                    st_next.state = jtl_pkg::JTL_ST_ILAS;
                end
                if (!hs) begin
                    st_next.ilas_wait = 1'b0;
                end
            end
            jtl_pkg::JTL_ST_ILAS: begin
                // alignment words are never scrambled
                st_next.out.data = rep8(8'h00);
                st_next.out.ctrl = 8'h00;
                st_next.out.mf_start = (st_reg.frame_cnt == '0);
                if (st_reg.frame_cnt == '0) begin
                    st_next.out.data[63:56] = jtl_pkg::JTL_K28_0;
                    st_next.out.ctrl[7] = 1'b1;
                end
                if (mf_edge) begin
                    st_next.out.data[7:0] = jtl_pkg::JTL_K28_3;
                    st_next.out.ctrl[0] = 1'b1;
                    st_next.ilas_mf = st_reg.ilas_mf + 2'h1;
                    if (st_reg.ilas_mf == 2'(jtl_pkg::JTL_ILAS_MF - 1)) begin
                        st_next.state = jtl_pkg::JTL_ST_DATA;
                    end
                end
                st_next.out_valid = 1'b1;
                if (!hs) begin
                    st_next.state = jtl_pkg::JTL_ST_CGS;
                end
            end
            jtl_pkg::JTL_ST_DATA: begin
                st_next.out.mf_start = mf_edge;
                st_next.out.ctrl = '0;
                st_next.out_valid = buf_valid;
                // plain sync header only; no CRC3, no command channel
                st_next.out.sync_hdr = (st_reg.cfg.code == jtl_pkg::JTL_CODE_64B66B) ?
                    jtl_pkg::JTL_SH_DATA : 2'h0;
                st_next.out.data = buf_data;
                if (buf_valid && st_reg.cfg.scr_en) begin
                    if (st_reg.cfg.code == jtl_pkg::JTL_CODE_64B66B) begin
                        // word-wise self-sync scrambler, 1+x^39+x^58
                        st_next.out.data = buf_data ^ {6'h0, st_reg.scr64} ^
                            {st_reg.scr64[38:0], 25'h0};
                        st_next.scr64 = st_next.out.data[57:0];
                    end else begin
                        st_next.out.data = buf_data ^ {4{st_reg.scr, 1'b0}};
                        st_next.scr = st_next.out.data[14:0];
                    end
                end
                if (st_reg.cfg.code == jtl_pkg::JTL_CODE_8B10B) begin
                    if (!hs) begin
                        st_next.state = jtl_pkg::JTL_ST_CGS;
                    end
                end else if (st_reg.cfg.sync_for_osc && hs && !st_reg.hs_prev) begin
                    st_next.osc_sync = 1'b1;
                end
            end
            default: begin
                st_next.state = jtl_pkg::JTL_ST_IDLE;
            end
        endcase
        if (!i_link_en) begin
            st_next.state = jtl_pkg::JTL_ST_IDLE;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_reg <= '0;
            st_reg.cfg.k_frames <= jtl_pkg::JTL_K_DEFAULT;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_lane_en = st_reg.lane_en;
    assign o_lane_word = st_reg.out;
    assign o_lane_valid = st_reg.out_valid;
    assign o_fec_en = st_reg.cfg.fec_en;
    assign o_osc_sync = st_reg.osc_sync;
    assign o_state = st_reg.state;

endmodule

`default_nettype wire

// ---- test/jtl_tx_link_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module jtl_tx_link_assertions #(
    parameter int LANES = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire jtl_pkg::jtl_cfg_t i_cfg,
    input wire logic i_link_en,
    input wire logic i_handshake_single_ended_input,
    input wire logic [LANES-1:0] o_lane_en,
    input wire jtl_pkg::jtl_lane_word_t o_lane_word,
    input wire logic o_lane_valid,
    input wire logic o_fec_en,
    input wire logic o_osc_sync,
    input wire logic [1:0] o_state
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------------------
    // alignment length counter
    // ------------------------------------------------------------
    logic [10:0] ilas_reg, ilas_next, k4;
    logic [LANES-1:0] mask;
    always_comb begin
        ilas_next = (o_state == 2'h2) ? ilas_reg + 11'h1 : 11'h0;
        k4 = (i_cfg.k_frames == 9'h0) ? 11'h80 : {i_cfg.k_frames, 2'h0};
        mask = (i_cfg.lanes >= LANES) ? '1 : LANES'((1 << i_cfg.lanes) - 1);
    end
    always_ff @(posedge i_core_clk) begin
        ilas_reg <= i_rst_n ? ilas_next : 11'h0;
    end
    AST_CGS_COMMA: assert property (o_state == 2'h1 && $past(o_state) == 2'h1 && o_lane_valid |->
        o_lane_word.data == {8{jtl_pkg::JTL_K28_5}} && o_lane_word.ctrl == 8'hff)
        else $error("comma stream wrong");
    AST_WAIT_HS: assert property ((!i_handshake_single_ended_input)[*5] |->
        o_state != 2'h2) else $error("alignment without handshake");
    AST_ILAS_FIRST: assert property ($rose(o_state == 2'h2) |=>
        o_lane_word.data[63:56] == jtl_pkg::JTL_K28_0 && o_lane_word.mf_start)
        else $error("bad start char");
    AST_ILAS_LAST: assert property (o_state == 2'h2 ##1 o_state == 2'h3 |->
        o_lane_word.data[7:0] == jtl_pkg::JTL_K28_3) else $error("bad end char");
    AST_ILAS_LEN: assert property ($past(o_state) == 2'h2 && o_state == 2'h3 |->
        ilas_reg == k4) else $error("alignment length wrong");
    AST_64_DATA: assert property (o_state == 2'h0 && i_link_en && i_cfg.code |=>
        o_state == 2'h3) else $error("64b start wrong");
    AST_8B_CGS: assert property (o_state == 2'h0 && i_link_en && !i_cfg.code |=>
        o_state == 2'h1) else $error("8b start wrong");
    AST_SYNC_HDR: assert property (o_lane_valid && o_state == 2'h3 && i_cfg.code |->
        o_lane_word.sync_hdr == jtl_pkg::JTL_SH_DATA) else $error("sync header wrong");
    AST_FEC: assert property (o_fec_en |-> i_cfg.code && i_cfg.fec_en)
        else $error("fec outside 64b");
    AST_LANE_EN: assert property ($past(o_state) != 2'h0 && o_state != 2'h0 |->
        o_lane_en == mask) else $error("lane mask wrong");
    AST_HS_IGNORED: assert property (o_state == 2'h3 && i_cfg.code && i_link_en |=>
        o_state == 2'h3) else $error("64b link left data");
    COV_ILAS: cover property ($rose(o_state == 2'h2));
    COV_OSC: cover property (o_osc_sync);
    COV_64: cover property (o_lane_valid && o_state == 2'h3 && i_cfg.code);
endmodule
bind jtl_tx_link jtl_tx_link_assertions #(.LANES(LANES)) chk_u (.*);
`default_nettype wire

// ---- test/jtl_rx_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module jtl_rx_model (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire jtl_pkg::jtl_lane_word_t i_lane_word,
    input wire logic i_lane_valid,
    input wire logic i_slow,
    input wire logic i_drop,
    input wire logic i_force,
    output logic o_hs
);
    // ------------------------------------------------------------
    // receiver handshake
    // ------------------------------------------------------------
    logic [4:0] cnt_reg;
    logic comma;
    assign comma = i_lane_valid && i_lane_word.data == {8{jtl_pkg::JTL_K28_5}};
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n || i_drop) begin
            cnt_reg <= 5'h0;
            o_hs <= 1'b0;
        end else begin
            // slow mode waits longer, like a receiver holding for its boundary
            cnt_reg <= comma ? cnt_reg + {4'h0, cnt_reg != 5'h1f} : 5'h0;
            if (i_force || cnt_reg >= (i_slow ? 5'h14 : 5'h4)) begin
                o_hs <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/jtl_tx_link_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module jtl_tx_link_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic link_en = 1'b0;
    logic sysref = 1'b0;
    logic valid = 1'b0;
    logic slow = 1'b0;
    logic drop = 1'b0;
    logic frc = 1'b0;
    jtl_pkg::jtl_cfg_t cfg = '0;
    jtl_pkg::jtl_word_t word = '0;
    wire logic hs;
    logic ready, lv, fec, osc;
    logic [15:0] lane_en;
    logic [1:0] st;
    jtl_pkg::jtl_lane_word_t lw;
    int error_cnt = 0;
    int n_checks = 0;
    jtl_tx_link #(.LANES(16)) dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_cfg(cfg),
        .i_link_en(link_en), .i_handshake_single_ended_input(hs), .i_sysref(sysref),
        .i_valid(valid), .o_ready(ready), .i_word(word), .o_lane_en(lane_en),
        .o_lane_word(lw), .o_lane_valid(lv), .o_fec_en(fec), .o_osc_sync(osc), .o_state(st));
    jtl_rx_model rx_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_lane_word(lw),
        .i_lane_valid(lv), .i_slow(slow), .i_drop(drop), .i_force(frc), .o_hs(hs));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wait_st(input logic [1:0] s);
        int n;
        n = 0;
        while (st !== s && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(st, s);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_8b(input logic s);
        logic [63:0] w [2];
        int n;
        w[0] = 64'h0123456789abcdef;
        w[1] = 64'hfedcba9876543210;
        @(posedge clk);
        slow <= s;
        cfg <= '{jtl_pkg::JTL_CODE_8B10B, 5'd4, 1'b1, 1'b0, 9'd4, 1'b0};
        valid <= 1'b1;
        word <= w[0];
        @(posedge clk);
        word <= w[1];
        @(posedge clk);
        // third word offered while full must not be taken
        word <= 64'h0;
        repeat (2) @(posedge clk);
        #1 chk(ready, 1'b0);
        @(posedge clk);
        valid <= 1'b0;
        link_en <= 1'b1;
        sysref <= 1'b1;
        wait_st(2'h1);
        @(posedge clk);
        sysref <= 1'b0;
        #1 chk({lw.ctrl, lw.data[55:0]}, {8'hff, {7{jtl_pkg::JTL_K28_5}}});
        repeat (4) @(posedge clk);
        #1 chk(lw.mf_start, 1'b0);
        @(posedge clk);
        #1 chk(lw.mf_start, 1'b1);
        wait_st(2'h3);
        chk({lane_en, fec}, {16'h000f, 1'b0});
        n = 0;
        while (!(lv === 1'b1 && lw.data === w[0]) && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(lw.data, w[0]);
        @(posedge clk);
        #1 chk({lv, lw.data[62:0]}, {1'b1, w[1][62:0]});
        @(posedge clk);
        drop <= 1'b1;
        wait_st(2'h1);
        @(posedge clk);
        drop <= 1'b0;
        link_en <= 1'b0;
        wait_st(2'h0);
    endtask
    task automatic t_64;
        int n;
        int p;
        @(posedge clk);
        cfg <= '{jtl_pkg::JTL_CODE_64B66B, 5'd20, 1'b1, 1'b0, 9'd0, 1'b1};
        link_en <= 1'b1;
        valid <= 1'b1;
        word <= 64'h5a5a5a5a5a5a5a5a;
        @(posedge clk);
        valid <= 1'b0;
        #1 chk(st, 2'h3);
        chk({lane_en, fec}, {16'hffff, 1'b1});
        n = 0;
        while (lv !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({lw.sync_hdr, lw.data === 64'h5a5a5a5a5a5a5a5a}, 3'h2);
        @(posedge clk);
        frc <= 1'b1;
        p = 0;
        repeat (12) begin
            @(posedge clk);
            #1;
            p += osc;
        end
        chk({p[3:0], st}, 6'h7);
        @(posedge clk);
        link_en <= 1'b0;
        frc <= 1'b0;
        wait_st(2'h0);
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk({ready, lv, st}, 4'h8);
        t_8b(1'b0);
        t_8b(1'b1);
        t_64();
        stop_test();
    end
endmodule
`default_nettype wire
